// [rtl/pac_pkg.sv]
// Overview of operation
// - fraction is 22 bits: reg0 bits 8:0, reg1 bits 8:0, reg2 bits 3:0 on top
// - integer ratio part comes from bits 7:4 of reg2
// - reads of reg0 and reg1 return the identification code, not the fraction
// - continuous readback disables identification code on reg0 and reg1 reads
// - reads of reg2 return the silicon revision number
// - bit 0 of reg3: 0 passes oscillator clock, 1 divides it by two
// - receiver mode: post divider picks 256fs or 128fs, second pll's ignored
// - receiver mode: device drives output divider itself, second pll's field ignored
// - user mode: output division from output divider field plus post divider bit
// - reset values: fraction 100100001, 101111110, 1101; integer 0111; divider 10
// - readback register at 34 holds enable, continuous and 3-bit source, reset zero
package pac_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 9;
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
	localparam logic [4:0] CNT_FRAME_DONE = 5'h10;
	// register addresses
	localparam logic [6:0] ADDR_FRAC_LOW = 7'h00;
	localparam logic [6:0] ADDR_FRAC_MID = 7'h01;
	localparam logic [6:0] ADDR_INT_FRAC_HIGH = 7'h02;
	localparam logic [6:0] ADDR_DIVIDER_SEL = 7'h03;
	localparam logic [6:0] ADDR_READBACK = 7'h34;
	// reset values
	localparam logic [8:0] RST_FRAC_LOW = 9'h121;
	localparam logic [8:0] RST_FRAC_MID = 9'h17e;
	localparam logic [8:0] RST_INT_FRAC_HIGH = 9'h07d;
	localparam logic [8:0] RST_DIVIDER_SEL = 9'h014;
	localparam logic [8:0] RST_READBACK = 9'h000;
	// divider select fields
	localparam int BIT_INPUT_DIV = 0;
	localparam int BIT_POST_DIV = 1;
	localparam int BIT_OUTSEL_LO = 3;
	localparam int BIT_OUTSEL_HI = 4;
	localparam logic [8:0] DIVIDER_SEL_MASK = 9'h01b;
	localparam logic [8:0] DIVIDER_SEL_FIXED = 9'h004;
	// integer / fraction high fields
	localparam int INT_LO = 4;
	localparam int INT_HI = 7;
	localparam int FRACH_HI = 3;
	localparam logic [8:0] INT_FRAC_HIGH_MASK = 9'h0ff;
	// readback control fields
	localparam int BIT_RB_EN = 4;
	localparam int BIT_RB_CONT = 3;
	localparam logic [8:0] READBACK_MASK = 9'h01f;
	typedef enum logic [1:0] {
		PAC_IDLE = 2'b00,
		PAC_ADDR = 2'b01,
		PAC_DATA = 2'b10
	} pac_phase_type;
endpackage

// [rtl/pac_pll_a_regs.sv]
`timescale 1ns/1ps
module pac_pll_a_regs #(
	parameter logic [8:0] ID_LOW_VALUE  = 9'h0a5, // arbitrary value
	parameter logic [8:0] ID_HIGH_VALUE = 9'h05a, // arbitrary value
	parameter logic [8:0] REVISION      = 9'h001  // arbitrary value
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// serial control port, sampled on clk
	input  wire logic        ctl_sclk,
	input  wire logic        ctl_sdin,
	input  wire logic        ctl_cs_n,
	output logic             ctl_sdout,
	// clocking mode and second pll settings
	input  wire logic        pll_rx_mode,
	input  wire logic [1:0]  rx_auto_output_divider_sel,
	input  wire logic        pll_b_post_divider,
	input  wire logic [1:0]  pll_b_output_divider_sel,
	// pll a configuration
	output logic [21:0]      pll_a_fraction,
	output logic [3:0]       pll_a_integer,
	output logic             pll_a_input_divider,
	output logic             pll_a_post_divider,
	output logic [1:0]       pll_a_output_divider_sel,
	output logic [2:0]       pll_a_output_division,
	// readback control
	output logic             readback_enable,
	output logic             continuous_readback,
	output logic [2:0]       readback_source_sel
);
	// how a control frame is handled, all in the clk domain:
	// - a falling cs_n opens a frame and clears the bit counter
	// - each rising sclk shifts one sdin bit in, msb first: 7 address bits, then 9 data bits
	// - once the seventh address bit is in, a read frame loads its answer for sdout
	// - each falling sclk after that moves one answer bit onto sdout, msb first
	// - a rising cs_n closes the frame; only a frame of 16 or more bits may write, using its first 16
	// sclk and cs_n are edge-detected against their last sample, so each level must
	// stand for at least two clk cycles; a faster serial clock would lose edges
	// while readback is enabled every frame is a read; a read can then never
	// overwrite a register, at the cost that only a reset leaves readback mode
	// stored fields feed the pll settings through one more register stage, so they
	// all move together two clk edges after the frame closes, never mid-frame
	// the second pll's post and output divider fields come in only to make plain
	// that they are ignored: in receiver mode hardware picks the output divider
	// the identity and revision answers are parameters with arbitrary defaults
	// unmapped addresses read as zero and ignore writes
	// unused upper bits of the stored registers are not kept; the divider
	// register always reads its bit 2 as one
	// reset is asynchronous; every field, derived ones included, takes its
	// power-up value, so the outputs are right from the first edge
	// no interrupt or buffering logic lives here
	typedef struct packed {
		// last samples of the serial pins, for edge detection
		logic                  sclk_q;
		logic                  cs_n_q;
		// frame engine: phase, bit count, input and answer shifters
		pac_pkg::pac_phase_type phase;
		logic [4:0]            cnt;
		logic [15:0]           shift;
		logic [8:0]            tx;
		logic                  rd_frame;
		logic                  sdout;
		// stored register fields
		logic [8:0]            frac_low;
		logic [8:0]            frac_mid;
		logic [8:0]            int_frac_high;
		logic [8:0]            divider_sel;
		logic [8:0]            readback;
		// derived pll settings, one register stage behind the fields
		logic [21:0]           fraction;
		logic [3:0]            integer_part;
		logic                  in_div;
		logic                  post_div;
		logic [1:0]            out_sel;
		logic [2:0]            out_division;
	} pac_state_type;

	// the whole state lives in one packed register
	pac_state_type st_ff;
	pac_state_type nxt_st;

	// value returned when a register is read
	// continuous readback swaps the identity answers for the stored fraction bits
	function automatic logic [8:0] read_value(input logic [6:0] addr, input pac_state_type s);
		logic cont;
		cont = s.readback[pac_pkg::BIT_RB_CONT];
		case (addr)
			pac_pkg::ADDR_FRAC_LOW:      read_value = cont ? s.frac_low : ID_LOW_VALUE;
			pac_pkg::ADDR_FRAC_MID:      read_value = cont ? s.frac_mid : ID_HIGH_VALUE;
			pac_pkg::ADDR_INT_FRAC_HIGH: read_value = REVISION;
			pac_pkg::ADDR_DIVIDER_SEL:   read_value = s.divider_sel;
			pac_pkg::ADDR_READBACK:      read_value = s.readback;
			default:                     read_value = 9'h000;
		endcase
	endfunction

	// serial framing, register writes and derived pll settings
	always_comb begin
		logic       sclk_rise;
		logic       sclk_fall;
		logic       frame_end;
		logic [6:0] waddr;
		logic [8:0] wdata;
		sclk_rise = ctl_sclk & ~st_ff.sclk_q;
		sclk_fall = ~ctl_sclk & st_ff.sclk_q;
		frame_end = ctl_cs_n & ~st_ff.cs_n_q;
		// address and data as they stand in the shifter at frame end
		waddr = st_ff.shift[pac_pkg::FRAME_BITS-1:pac_pkg::DATA_W];
		wdata = st_ff.shift[pac_pkg::DATA_W-1:0];
		// hold everything unless a branch below moves it
		nxt_st = st_ff;
		nxt_st.sclk_q = ctl_sclk;
		nxt_st.cs_n_q = ctl_cs_n;
		case (st_ff.phase)
			// a low cs_n opens a frame and restarts the count
			pac_pkg::PAC_IDLE: begin
				if (!ctl_cs_n) begin
					nxt_st.phase = pac_pkg::PAC_ADDR;
					nxt_st.cnt = 5'h00;
					nxt_st.rd_frame = 1'b0;
				end
			end
			pac_pkg::PAC_ADDR, pac_pkg::PAC_DATA: begin
				// one bit per rising sclk; bits past the sixteenth are dropped
				if (sclk_rise && st_ff.cnt != pac_pkg::CNT_FRAME_DONE) begin
					nxt_st.shift = {st_ff.shift[pac_pkg::FRAME_BITS-2:0], ctl_sdin};
					nxt_st.cnt = st_ff.cnt + 5'h01;
				end
				// address complete: a read frame loads the answer for the data phase
				if (st_ff.phase == pac_pkg::PAC_ADDR && st_ff.cnt == pac_pkg::CNT_ADDR_DONE) begin
					nxt_st.phase = pac_pkg::PAC_DATA;
					nxt_st.rd_frame = st_ff.readback[pac_pkg::BIT_RB_EN];
					nxt_st.tx = read_value(st_ff.shift[pac_pkg::ADDR_W-1:0], st_ff);
				end
				// data shifts out on falling sclk, msb first
				if (sclk_fall && st_ff.rd_frame && st_ff.phase == pac_pkg::PAC_DATA) begin
					nxt_st.sdout = st_ff.tx[pac_pkg::DATA_W-1];
					nxt_st.tx = {st_ff.tx[pac_pkg::DATA_W-2:0], 1'b0};
				end
				// rising cs_n closes the frame
				if (frame_end) begin
					nxt_st.phase = pac_pkg::PAC_IDLE;
					nxt_st.sdout = 1'b0;
					// short frames are dropped so a glitch never corrupts a register
					// a read frame never writes, so the answer cannot disturb the fields
					if (st_ff.cnt == pac_pkg::CNT_FRAME_DONE && !st_ff.rd_frame) begin
						case (waddr)
							pac_pkg::ADDR_FRAC_LOW:      nxt_st.frac_low = wdata;
							pac_pkg::ADDR_FRAC_MID:      nxt_st.frac_mid = wdata;
							pac_pkg::ADDR_INT_FRAC_HIGH: nxt_st.int_frac_high = wdata & pac_pkg::INT_FRAC_HIGH_MASK;
							pac_pkg::ADDR_DIVIDER_SEL:
								nxt_st.divider_sel = (wdata & pac_pkg::DIVIDER_SEL_MASK) | pac_pkg::DIVIDER_SEL_FIXED;
							pac_pkg::ADDR_READBACK:      nxt_st.readback = wdata & pac_pkg::READBACK_MASK;
							default: ;
						endcase
					end
				end
			end
			// an illegal phase falls back to idle
			default: nxt_st.phase = pac_pkg::PAC_IDLE;
		endcase
		// derived settings follow the stored fields one cycle later
		nxt_st.fraction = {st_ff.int_frac_high[pac_pkg::FRACH_HI:0], st_ff.frac_mid, st_ff.frac_low};
		nxt_st.integer_part = st_ff.int_frac_high[pac_pkg::INT_HI:pac_pkg::INT_LO];
		nxt_st.in_div = st_ff.divider_sel[pac_pkg::BIT_INPUT_DIV];
		nxt_st.post_div = st_ff.divider_sel[pac_pkg::BIT_POST_DIV];
		// second pll post and output fields are not consulted in either mode
		// receiver mode hands the output divider select to hardware
		if (pll_rx_mode) begin
			nxt_st.out_sel = rx_auto_output_divider_sel;
		end else begin
			nxt_st.out_sel = st_ff.divider_sel[pac_pkg::BIT_OUTSEL_HI:pac_pkg::BIT_OUTSEL_LO];
		end
		// division code: output divider select above the post divider bit
		nxt_st.out_division = {nxt_st.out_sel, st_ff.divider_sel[pac_pkg::BIT_POST_DIV]};
	end

	// single state register; reset values are constants only
	// the derived stage is loaded from the same constants, so no output glitches after reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			// serial engine starts idle
			st_ff.sclk_q <= 1'b0;
			st_ff.cs_n_q <= 1'b1;
			st_ff.phase <= pac_pkg::PAC_IDLE;
			st_ff.cnt <= 5'h00;
			st_ff.shift <= '0;
			st_ff.tx <= '0;
			st_ff.rd_frame <= 1'b0;
			st_ff.sdout <= 1'b0;
			// register fields and the derived stage take their power-up values
			st_ff.frac_low <= pac_pkg::RST_FRAC_LOW;
			st_ff.frac_mid <= pac_pkg::RST_FRAC_MID;
			st_ff.int_frac_high <= pac_pkg::RST_INT_FRAC_HIGH;
			st_ff.divider_sel <= pac_pkg::RST_DIVIDER_SEL;
			st_ff.readback <= pac_pkg::RST_READBACK;
			st_ff.fraction <= {pac_pkg::RST_INT_FRAC_HIGH[pac_pkg::FRACH_HI:0], pac_pkg::RST_FRAC_MID,
				pac_pkg::RST_FRAC_LOW};
			st_ff.integer_part <= pac_pkg::RST_INT_FRAC_HIGH[pac_pkg::INT_HI:pac_pkg::INT_LO];
			st_ff.in_div <= pac_pkg::RST_DIVIDER_SEL[pac_pkg::BIT_INPUT_DIV];
			st_ff.post_div <= pac_pkg::RST_DIVIDER_SEL[pac_pkg::BIT_POST_DIV];
			st_ff.out_sel <= pac_pkg::RST_DIVIDER_SEL[pac_pkg::BIT_OUTSEL_HI:pac_pkg::BIT_OUTSEL_LO];
			st_ff.out_division <= {pac_pkg::RST_DIVIDER_SEL[pac_pkg::BIT_OUTSEL_HI:pac_pkg::BIT_OUTSEL_LO],
				pac_pkg::RST_DIVIDER_SEL[pac_pkg::BIT_POST_DIV]};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs come straight from the state register
	assign ctl_sdout = st_ff.sdout;
	// pll a settings
	assign pll_a_fraction = st_ff.fraction;
	assign pll_a_integer = st_ff.integer_part;
	assign pll_a_input_divider = st_ff.in_div;
	assign pll_a_post_divider = st_ff.post_div;
	assign pll_a_output_divider_sel = st_ff.out_sel;
	assign pll_a_output_division = st_ff.out_division;
	// readback control fields; the source select sits below the continuous bit
	assign readback_enable = st_ff.readback[pac_pkg::BIT_RB_EN];
	assign continuous_readback = st_ff.readback[pac_pkg::BIT_RB_CONT];
	assign readback_source_sel = st_ff.readback[pac_pkg::BIT_RB_CONT-1:0];
endmodule

// [dv/pac_pll_a_regs_checker.sv]
`timescale 1ns/1ps
module pac_pll_a_regs_checker (
	// clock, reset and serial frame
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        ctl_cs_n,
	input wire logic        ctl_sdout,
	// mode inputs
	input wire logic        pll_rx_mode,
	input wire logic [1:0]  rx_auto_output_divider_sel,
	// watched outputs
	input wire logic [21:0] pll_a_fraction,
	input wire logic        pll_a_post_divider,
	input wire logic [1:0]  pll_a_output_divider_sel,
	input wire logic [2:0]  pll_a_output_division,
	input wire logic        readback_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// defaults on the first edge after release; rx mode would steer the divider select
	chk_reset_vals: assert property (!$past(arst_n) && !pll_rx_mode |-> pll_a_fraction == 22'h36fd21
		&& pll_a_output_division == 3'h4 && !readback_enable) else $error("reset values wrong");
	chk_idle_hold: assert property (ctl_cs_n[*4] |=> $stable(pll_a_fraction) && $stable(pll_a_post_divider))
		else $error("config moved without a frame");
	chk_frac_late: assert property ($changed(pll_a_fraction) |-> ctl_cs_n && $past(ctl_cs_n))
		else $error("fraction moved inside a frame");
	chk_rb_locks: assert property (readback_enable |=> $stable(pll_a_fraction)) else $error("read frame wrote");
	chk_rx_outsel: assert property (pll_rx_mode |=> pll_a_output_divider_sel == $past(rx_auto_output_divider_sel))
		else $error("rx divider select not followed");
	chk_user_hold: assert property ((!pll_rx_mode && ctl_cs_n)[*4] |=> $stable(pll_a_output_divider_sel))
		else $error("user divider select moved");
	chk_div_pair: assert property ($stable(pll_a_output_divider_sel) && $stable(pll_a_post_divider)
		|-> pll_a_output_division == {pll_a_output_divider_sel, pll_a_post_divider}) else $error("division wrong");
	chk_sdout_idle: assert property (ctl_cs_n[*3] |-> !ctl_sdout) else $error("read data outside frame");
	cov_rx: cover property (pll_rx_mode ##1 !pll_rx_mode);
	cov_rb: cover property ($rose(readback_enable));
	cov_read: cover property (!ctl_cs_n && ctl_sdout);
endmodule

bind pac_pll_a_regs pac_pll_a_regs_checker i_pac_pll_a_regs_checker (.*);

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
	logic        clk, arst_n, sclk, sdin, cs_n, rx, pb_post, sdout, o_in, o_post, rb_en, rb_cont, pb_in;
	logic [1:0]  rx_sel, pb_sel, o_sel;
	logic [2:0]  o_div, rb_src;
	logic [3:0]  o_int;
	logic [8:0]  rd, d;
	logic [21:0] o_frac;
	int          error_cnt, total_checks, a, r[int], seed = 92, q[6] = '{0, 1, 2, 3, 52, 16};
	localparam logic [8:0] IDL = 9'h0c3, IDH = 9'h03c, REV = 9'h002; // arbitrary identity values
	pac_pll_a_regs #(.ID_LOW_VALUE(IDL), .ID_HIGH_VALUE(IDH), .REVISION(REV)) i_pac_pll_a_regs (.clk(clk),
		.arst_n(arst_n), .ctl_sclk(sclk), .ctl_sdin(sdin), .ctl_cs_n(cs_n), .ctl_sdout(sdout), .pll_rx_mode(rx),
		.rx_auto_output_divider_sel(rx_sel), .pll_b_post_divider(pb_post), .pll_b_output_divider_sel(pb_sel),
		.pll_a_fraction(o_frac), .pll_a_integer(o_int), .pll_a_input_divider(o_in), .pll_a_post_divider(o_post),
		.pll_a_output_divider_sel(o_sel), .pll_a_output_division(o_div), .readback_enable(rb_en),
		.continuous_readback(rb_cont), .readback_source_sel(rb_src));
	// xorshift source, masked positive so modulo stays in range
	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed & 32'h7fffffff;
	endfunction
	// expected read answer from the model state
	function automatic int exp_rd(int aa);
		if (aa == 2) return REV;
		if (aa < 2) return r[52][3] ? r[aa] : (aa ? IDH : IDL);
		if (aa == 3) return r[3] & 9'h01b | 9'h004;
		return aa == 52 ? r[52] & 9'h01f : 0;
	endfunction
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one 16-bit frame; sclk low gets three cycles so read data has settled when sampled
	task automatic frame(int aa, logic [8:0] dd);
		logic [15:0] w;
		w = {aa[6:0], dd};
		cs_n = 0;
		cyc(2);
		for (int i = 15; i >= 0; i--) begin
			sclk = 0;
			sdin = w[i];
			cyc(3);
			rd = {rd[7:0], sdout};
			sclk = 1;
			cyc(2);
		end
		cs_n = 1;
		cyc(4);
		if (!r[52][4] && (aa < 4 || aa == 52)) r[aa] = dd;
	endtask
	task automatic chk_out();
		chk(o_frac, {r[2][3:0], r[1][8:0], r[0][8:0]});
		chk({o_int, o_in, o_post}, {r[2][7:4], r[3][0], r[3][1]});
		chk({o_sel, o_div}, {rx ? rx_sel : r[3][4:3], rx ? rx_sel : r[3][4:3], r[3][1]});
		chk({rb_en, rb_cont, rb_src}, r[52][4:0]);
	endtask
	task automatic rst();
		arst_n = 0;
		cyc(5);
		r = '{0: 9'h121, 1: 9'h17e, 2: 9'h07d, 3: 9'h014, 52: 0};
		arst_n = 1;
		cyc(2);
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// runs take about 9 us; a hang is cut at 60 us
	initial begin
		#60000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		{arst_n, sclk, sdin, rx, pb_post, rx_sel, pb_sel, rd} = 0;
		cs_n = 1;
		rst();
		chk_out();
		$display("reset test done");
		for (int k = 0; k < 12; k++) begin
			rx = k[2];
			rx_sel = 2'(rnd());
			{pb_post, pb_sel, pb_in} = 4'(rnd()); // second pll fields must not matter
			d = 9'(rnd());
			a = k % 5 == 4 ? 16 : k % 4;
			if (a == 2) d = 9'(d & 9'h10f | (5 + d % 9) << 4); // integer kept in 5..13
			if (a == 3 && rx) d[0] = pb_in;
			frame(a, d);
			chk_out();
		end
		$display("write test done");
		for (int j = 0; j < 2; j++) begin
			if (j) rst();
			frame(52, (j ? 9'h010 : 9'h018) | 9'(rnd() % 8));
			foreach (q[i]) begin
				frame(q[i], 9'(rnd()));
				chk(rd, exp_rd(q[i]));
			end
			chk_out();
		end
		$display("readback test done");
		report_and_stop();
	end
endmodule
